// *** hw/random_interval_pulse_pair_gen.sv ***
// random interval start/stop pulse pair generator for a time_to_amplitude_converter
// assumes all setting and enable inputs are slow panel levels from outside the clk domain
//
// Contract
// R1 - all timing derived from one reference clock
// R2 - start then stop, N periods apart, N>=2
// R3 - eleven doubling base periods, 10ns to 10.24us; code gives 20ns to 20.48us at 50 MHz
// R4 - N random, N=2 twice as likely
// R5 - range window bounds N, 80ns to 81.92us; code gives 160ns to 163.84us at 50 MHz
// R6 - controller sets range above base period
// R7 - at most one pair per range window
// R8 - pair only on trigger and tick coincidence
// R9 - trigger rate adjustable 100 to 10000/s
// R10 - continuous ungated tick each base period
// R11 - busy from start until its stop
// R12 - runs only with switch on and enable
// R13 - lamp lit while pairs are permitted
// R14 - start on tick, stop N ticks later
// R15 - trigger from pseudo-random compare threshold
`timescale 1ns/1ps
`default_nettype none

module random_interval_pulse_pair_gen (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        resetn,
  // panel settings
  input  wire  logic [3:0]  periodSel,
  input  wire  logic [3:0]  rangeSel,
  input  wire  logic [13:0] rateSet,
  // gating
  input  wire  logic        manualOn,
  input  wire  logic        extEnable,
  // pair outputs
  output logic              startPulse,
  output logic              stopPulse,
  output logic              busy,
  // monitor outputs
  output logic              periodTick,
  output logic              activeLamp
);

  // synchroniser stages; the first stage is read only by the second
  logic [3:0]  periodSelMeta_q;                              // first stage, period selector
  logic [3:0]  periodSelSync_q;                              // second stage, period selector
  logic [3:0]  rangeSelMeta_q;                               // first stage, range selector
  logic [3:0]  rangeSelSync_q;                               // second stage, range selector
  logic [13:0] rateMeta_q;                                   // first stage, rate
  logic [13:0] rateSync_q;                                   // second stage, rate
  logic [1:0]  gateMeta_q;                                   // first stage, switch and enable
  logic [1:0]  gateSync_q;                                   // second stage, switch and enable

  // counter widths, declared before any vector that is sized by them
  localparam int unsigned PERIOD_CNT_W_L = random_interval_pulse_pair_gen_pkg::PERIOD_CNT_W;
  localparam int unsigned WIN_CNT_W_L    = random_interval_pulse_pair_gen_pkg::WIN_CNT_W;

  // derived settings
  logic [3:0]  periodStep;                                   // clamped period step
  logic [3:0]  rangeStep;                                    // clamped range step
  logic [4:0]  rangeLog;                                     // window length as log2 base periods
  logic [4:0]  winLog;                                       // window length as log2 period ticks
  logic [PERIOD_CNT_W_L-1:0] periodLen;                      // cycles per selected period
  logic [WIN_CNT_W_L-1:0]    winLen;                         // period ticks per window
  logic        enabled;                                      // switch on and enable high

  // timing state
  logic [PERIOD_CNT_W_L-1:0] periodCnt_q;                    // cycle count inside a period
  logic [WIN_CNT_W_L-1:0]    winCnt_q;                       // tick count inside a window
  logic [WIN_CNT_W_L-1:0]    remain_q;                       // ticks left until stop
  logic        fired_q;                                      // a pair already started this window
  random_interval_pulse_pair_gen_pkg::seq_state_type state_q; // pair sequencer

  // registered outputs
  logic        start_q;
  logic        stop_q;
  logic        tick_q;
  logic        lamp_q;

  // combinational events
  logic        tickNow;                                      // last cycle of a period
  logic        winEnd;                                       // last tick of a window
  logic        trigger;                                      // random trigger pulse
  logic [15:0] drawWord;                                     // random draw word
  logic [WIN_CNT_W_L-1:0]    drawRaw;                        // draw in 1..winLen
  logic [WIN_CNT_W_L-1:0]    multN;                          // chosen multiplier
  logic        startNow;                                     // coincidence taken
  logic        stopNow;                                      // last tick of the interval

  // two-flop synchronisers for every panel setting and gating input; resetn is used as it arrives
  always_ff @(posedge clk) begin
    if (!resetn) begin
      periodSelMeta_q <= 4'h0;
      periodSelSync_q <= 4'h0;
      rangeSelMeta_q  <= 4'h0;
      rangeSelSync_q  <= 4'h0;
      rateMeta_q      <= 14'h0000;
      rateSync_q      <= 14'h0000;
      gateMeta_q      <= 2'h0;
      gateSync_q      <= 2'h0;
    end else begin
      periodSelMeta_q <= periodSel;
      periodSelSync_q <= periodSelMeta_q;
      rangeSelMeta_q  <= rangeSel;
      rangeSelSync_q  <= rangeSelMeta_q;
      rateMeta_q      <= rateSet;
      rateSync_q      <= rateMeta_q;
      gateMeta_q      <= {manualOn, extEnable};
      gateSync_q      <= gateMeta_q;
    end
  end

  // pair generation is permitted only with the switch on and the enable high
  assign enabled = gateSync_q[1] & gateSync_q[0];          // R12

  // clamp selectors above the top step to the top step
  assign periodStep = (periodSelSync_q > random_interval_pulse_pair_gen_pkg::PERIOD_SEL_MAX) ?
                      random_interval_pulse_pair_gen_pkg::PERIOD_SEL_MAX : periodSelSync_q;
  assign rangeStep  = (rangeSelSync_q > random_interval_pulse_pair_gen_pkg::RANGE_SEL_MAX) ?
                      random_interval_pulse_pair_gen_pkg::RANGE_SEL_MAX : rangeSelSync_q;

  // period length doubles with each step from the base period
  assign periodLen = PERIOD_CNT_W_L'(random_interval_pulse_pair_gen_pkg::BASE_CYC) << periodStep; // R3 R1

  // window in base periods is eight times two to the range step; in ticks divide by the period
  assign rangeLog = 5'(rangeStep) + 5'(random_interval_pulse_pair_gen_pkg::RANGE_BASE_LOG); // R5
  // a range not above the period collapses to a one-tick window; that setting is the
  // controller's mistake and the block only stays well behaved under it
  assign winLog   = (rangeLog > 5'(periodStep)) ? (rangeLog - 5'(periodStep)) : 5'h00; // R6
  assign winLen   = WIN_CNT_W_L'(1) << winLog;

  // a tick ends each period; the compare is >= so a shorter new setting cannot run away
  assign tickNow = (periodCnt_q >= (periodLen - PERIOD_CNT_W_L'(1)));   // R1
  assign winEnd  = tickNow && (winCnt_q >= (winLen - WIN_CNT_W_L'(1)));

  // free-running period counter; runs whether or not pairs are enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      periodCnt_q <= '0;
    end else if (tickNow) begin
      periodCnt_q <= '0;                                     // R10
    end else begin
      periodCnt_q <= periodCnt_q + PERIOD_CNT_W_L'(1);
    end
  end

  // window counter steps once per period tick
  always_ff @(posedge clk) begin
    if (!resetn) begin
      winCnt_q <= '0;
    end else if (winEnd) begin
      winCnt_q <= '0;                                        // R5
    end else if (tickNow) begin
      winCnt_q <= winCnt_q + WIN_CNT_W_L'(1);
    end
  end

  // random trigger source
  random_trigger_source trigSrc (
    .clk      (clk),
    .resetn   (resetn),
    .rateSet  (rateSync_q),
    .trigger  (trigger),
    .drawWord (drawWord)
  );

  // draw r uniform in 1..winLen and fold r=1 onto 2, so two is twice as likely
  assign drawRaw = (WIN_CNT_W_L'(drawWord) & (winLen - WIN_CNT_W_L'(1))) + WIN_CNT_W_L'(1); // R4
  assign multN   = (drawRaw < WIN_CNT_W_L'(2)) ? WIN_CNT_W_L'(2) : drawRaw;                    // R2 R4

  // a start needs trigger and tick together, gating, an idle sequencer and a fresh window
  assign startNow = trigger && tickNow && enabled &&                                          // R8
                    (state_q == random_interval_pulse_pair_gen_pkg::SEQ_IDLE) && !fired_q;   // R7

  // the stop falls on the Nth tick after the start tick
  assign stopNow = (state_q == random_interval_pulse_pair_gen_pkg::SEQ_TIMING) && tickNow &&
                   (remain_q == WIN_CNT_W_L'(1));                                             // R14

  // one pair per window: the flag clears at the window's last tick, but a start on that
  // same tick still belongs to the closing window, so it is not lost and not carried over
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fired_q <= 1'b0;
    end else if (winEnd) begin
      fired_q <= 1'b0;                                       // R7
    end else if (startNow) begin
      fired_q <= 1'b1;                                       // R7
    end
  end

  // pair sequencer; once started a pair always completes, even if gating drops,
  // so the converter never sees a start without its stop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q  <= random_interval_pulse_pair_gen_pkg::SEQ_IDLE;
      remain_q <= '0;
    end else begin
      unique case (state_q)
        random_interval_pulse_pair_gen_pkg::SEQ_IDLE: begin
          if (startNow) begin
            state_q  <= random_interval_pulse_pair_gen_pkg::SEQ_TIMING;
            remain_q <= multN;                               // R14
          end
        end
        random_interval_pulse_pair_gen_pkg::SEQ_TIMING: begin
          if (stopNow) begin
            state_q  <= random_interval_pulse_pair_gen_pkg::SEQ_IDLE; // R2
          end else if (tickNow) begin
            remain_q <= remain_q - WIN_CNT_W_L'(1);          // R14
          end
        end
        default: begin
          state_q  <= random_interval_pulse_pair_gen_pkg::SEQ_IDLE;
          remain_q <= '0;
        end
      endcase
    end
  end

  // output pulses share one register stage so start, stop and tick stay aligned
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      tick_q  <= 1'b0;
    end else begin
      start_q <= startNow;                                   // R14
      stop_q  <= stopNow;                                    // R2
      tick_q  <= tickNow;                                    // R10
    end
  end

  // lamp follows the permission, not actual pair activity
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lamp_q <= 1'b0;
    end else begin
      lamp_q <= enabled;                                     // R13
    end
  end

  // busy comes straight from the sequencer state register
  assign busy       = (state_q == random_interval_pulse_pair_gen_pkg::SEQ_TIMING); // R11
  assign startPulse = start_q;
  assign stopPulse  = stop_q;
  assign periodTick = tick_q;
  assign activeLamp = lamp_q;

endmodule // random_interval_pulse_pair_gen

`default_nettype wire

// *** hw/random_interval_pulse_pair_gen_pkg.sv ***
// constants for the random interval start/stop pulse pair generator
// assumes clk is the timing reference; every count below is derived from its period
`default_nettype none
package random_interval_pulse_pair_gen_pkg;

  // reference clock
  localparam int unsigned CLK_PERIOD_PS   = 20000;                 // 20 ns at 50 MHz
  localparam longint     CLK_HZ          = 64'd50000000;          // clock rate in hertz

  // base period: 10 ns at the shortest setting, rounded up to whole cycles, never below one
  localparam int unsigned BASE_PERIOD_PS  = 10000;
  localparam int unsigned BASE_CYC_RAW    = (BASE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BASE_CYC        = (BASE_CYC_RAW < 1) ? 1 : BASE_CYC_RAW;

  // period selector: 11 doubling steps, 20 ns up to 20.48 us at 50 MHz
  localparam int unsigned PERIOD_STEPS    = 11;
  localparam logic [3:0]  PERIOD_SEL_MAX  = 4'(PERIOD_STEPS - 1);

  // range selector: doubling steps from 160 ns (eight base periods) up to 163.84 us
  localparam int unsigned RANGE_MIN_PS    = 80000;
  localparam int unsigned RANGE_STEPS     = 11;
  localparam logic [3:0]  RANGE_SEL_MAX   = 4'(RANGE_STEPS - 1);
  localparam logic [3:0]  RANGE_BASE_LOG  = 4'($clog2(RANGE_MIN_PS / BASE_PERIOD_PS));

  // counter widths
  localparam int unsigned PERIOD_CNT_W    = 16;                    // cycles of one selected period
  localparam int unsigned WIN_CNT_W       = 15;                    // period ticks per window

  // trigger rate in events per second, clamped to the adjustable span
  localparam int unsigned RATE_W          = 14;
  localparam logic [13:0] RATE_MIN        = 14'h0064;              // 100 per second
  localparam logic [13:0] RATE_MAX        = 14'h2710;              // 10,000 per second
  localparam logic [31:0] RATE_SCALE      = 32'(64'h0000_0001_0000_0000 / CLK_HZ);

  // pseudo-random generators: taps and nonzero seeds
  localparam logic [31:0] TRIG_TAPS       = 32'h8020_0003;
  localparam logic [31:0] TRIG_SEED       = 32'h1d5a_c3e7;
  localparam logic [15:0] DRAW_TAPS       = 16'hb400;
  localparam logic [15:0] DRAW_SEED       = 16'h6b29;

  // pair sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b01,
    SEQ_TIMING = 2'b10
  } seq_state_type;

endpackage

`default_nettype wire

// *** hw/random_trigger_source.sv ***
// pseudo-random trigger source and random draw word
// assumes rateSet is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none

module random_trigger_source (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        resetn,
  // rate setting, events per second
  input  wire  logic [13:0] rateSet,
  // random outputs
  output logic              trigger,
  output logic [15:0]       drawWord
);

  logic [31:0] trigLfsr_q;                                   // trigger sequence state
  logic [15:0] drawLfsr_q;                                   // independent draw sequence state
  logic        trigger_q;                                    // registered trigger pulse
  logic [13:0] rateClamped;                                  // rate held inside its span
  logic [31:0] threshold;                                    // per-cycle compare level

  // clamp the rate: out-of-span settings behave like the nearest end
  always_comb begin
    if (rateSet < random_interval_pulse_pair_gen_pkg::RATE_MIN) begin
      rateClamped = random_interval_pulse_pair_gen_pkg::RATE_MIN;
    end else if (rateSet > random_interval_pulse_pair_gen_pkg::RATE_MAX) begin
      rateClamped = random_interval_pulse_pair_gen_pkg::RATE_MAX;
    end else begin
      rateClamped = rateSet;
    end
  end

  // probability per cycle is threshold / 2^32, so the mean rate is rate per second
  assign threshold = 32'(32'(rateClamped) * random_interval_pulse_pair_gen_pkg::RATE_SCALE); // R15 R9

  // galois shift for the trigger sequence
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trigLfsr_q <= random_interval_pulse_pair_gen_pkg::TRIG_SEED;
    end else if (trigLfsr_q[0]) begin
      trigLfsr_q <= (trigLfsr_q >> 1) ^ random_interval_pulse_pair_gen_pkg::TRIG_TAPS;
    end else begin
      trigLfsr_q <= trigLfsr_q >> 1;
    end
  end

  // separate sequence for the multiplier draw; sharing the trigger word would bias it,
  // since a taken trigger implies its upper bits are zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      drawLfsr_q <= random_interval_pulse_pair_gen_pkg::DRAW_SEED;
    end else if (drawLfsr_q[0]) begin
      drawLfsr_q <= (drawLfsr_q >> 1) ^ random_interval_pulse_pair_gen_pkg::DRAW_TAPS;
    end else begin
      drawLfsr_q <= drawLfsr_q >> 1;
    end
  end

  // compare against the threshold
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trigger_q <= 1'b0;
    end else begin
      trigger_q <= (trigLfsr_q < threshold);                 // R15
    end
  end

  assign trigger  = trigger_q;
  assign drawWord = drawLfsr_q;

endmodule // random_trigger_source

`default_nettype wire

// *** sim/random_interval_pulse_pair_gen_chk.sv ***
// port assertions for the pulse pair generator
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module random_interval_pulse_pair_gen_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // gating
  input wire logic manualOn,
  input wire logic extEnable,
  // outputs watched
  input wire logic startPulse,
  input wire logic stopPulse,
  input wire logic busy,
  input wire logic periodTick,
  input wire logic activeLamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // pair edges sit on period ticks
  property p_start_tick; startPulse |-> periodTick; endproperty
  a_start_tick: assert property (p_start_tick) else $error("start off tick");
  property p_stop_tick; stopPulse |-> periodTick; endproperty
  a_stop_tick: assert property (p_stop_tick) else $error("stop off tick");
  // busy framing
  property p_busy_start; startPulse |-> busy; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy low at start");
  property p_busy_stop; stopPulse |-> !busy && $past(busy); endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("busy wrong at stop");
  property p_busy_rise; $rose(busy) |-> startPulse; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose alone");
  property p_busy_hold; busy |=> busy || stopPulse; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  // at least two periods, so no stop right after start
  property p_min_gap; startPulse |=> !stopPulse; endproperty
  a_min_gap: assert property (p_min_gap) else $error("stop too soon");
  property p_no_restart; startPulse |-> !$past(busy); endproperty
  a_no_restart: assert property (p_no_restart) else $error("start while busy");
  // lamp and start share the same synchronised gate
  property p_gated; startPulse |-> activeLamp; endproperty
  a_gated: assert property (p_gated) else $error("start while gated");
  property p_lamp_on; (manualOn && extEnable) [*4] |-> activeLamp; endproperty
  a_lamp_on: assert property (p_lamp_on) else $error("lamp not lit");
  property p_lamp_off; (!(manualOn && extEnable)) [*4] |-> !activeLamp; endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while off");
  // main scenarios reached
  c_pair: cover property (startPulse ##[2:300] stopPulse);
  c_shortest: cover property (startPulse ##2 stopPulse);
  c_lamp_off: cover property ($fell(activeLamp));
endmodule // random_interval_pulse_pair_gen_chk
bind random_interval_pulse_pair_gen random_interval_pulse_pair_gen_chk u_chk (.clk(clk), .resetn(resetn),
  .manualOn(manualOn), .extEnable(extEnable), .startPulse(startPulse), .stopPulse(stopPulse), .busy(busy),
  .periodTick(periodTick), .activeLamp(activeLamp));
`default_nettype wire

// *** sim/random_interval_pulse_pair_gen_tb.sv ***
// self-checking bench for the pulse pair generator
// assumes a 50 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module random_interval_pulse_pair_gen_tb;
  localparam int TIMEOUT = 100000; // cycles; rows, gating and reset need about 60000
  typedef struct { logic [3:0] p; logic [3:0] r; logic [13:0] rate; int pairs; } row_type;
  // range always above period, so every row is a legal setting
  row_type rows [4] = '{'{4'h0, 4'h0, 14'h2710, 1}, '{4'h0, 4'h2, 14'h3fff, 1},
                        '{4'h1, 4'h0, 14'h2710, 1}, '{4'h2, 4'h0, 14'h2710, 1}};
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  periodSel = 4'h0;
  logic [3:0]  rangeSel = 4'h0;
  logic [13:0] rateSet = 14'h2710;
  logic        manualOn = 1'b1;
  logic        extEnable = 1'b1;
  logic        startPulse, stopPulse, busy, periodTick, activeLamp;
  logic [31:0] lastSpan;
  logic [15:0] pairCount, base;
  logic        orderFault;
  int          errCount = 0, testsRun = 0, cycles = 0, plen, nmax, k, starts, ticks;
  random_interval_pulse_pair_gen dut (.clk(clk), .resetn(resetn), .periodSel(periodSel), .rangeSel(rangeSel),
    .rateSet(rateSet), .manualOn(manualOn), .extEnable(extEnable), .startPulse(startPulse),
    .stopPulse(stopPulse), .busy(busy), .periodTick(periodTick), .activeLamp(activeLamp));
  tac_model u_tac (.clk(clk), .startPulse(startPulse), .stopPulse(stopPulse), .lastSpan(lastSpan),
    .pairCount(pairCount), .orderFault(orderFault));
  initial begin
    forever #10 clk = ~clk;
  end
  // verdict, from the main sequence or the watchdog
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog against a pair that never comes
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      errCount++;
      final_report();
    end
  end
  // one gap between period ticks, in cycles
  task automatic tick_gap(output int n);
    while (periodTick !== 1'b1) @(negedge clk);
    @(negedge clk);
    n = 1;
    while (periodTick !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    // ordinary cases: each row sets period, range and rate
    for (int i = 0; i < 4; i++) begin
      periodSel = rows[i].p;
      rangeSel = rows[i].r;
      rateSet = rows[i].rate;
      plen = int'(random_interval_pulse_pair_gen_pkg::BASE_CYC) << rows[i].p;
      nmax = (int'(random_interval_pulse_pair_gen_pkg::RANGE_MIN_PS /
                   random_interval_pulse_pair_gen_pkg::BASE_PERIOD_PS) << rows[i].r) >> rows[i].p;
      if (nmax < 2) nmax = 2;
      repeat (8) @(negedge clk);
      while (busy !== 1'b0) @(negedge clk);
      tick_gap(k);
      tick_gap(k);
      `CHECK(k, plen)
      base = pairCount;
      while (pairCount !== base + 16'(rows[i].pairs)) begin
        @(negedge clk);
      end
      `CHECK(lastSpan % 32'(plen), 32'h0)
      `CHECK(1'(lastSpan >= 32'(2 * plen) && lastSpan <= 32'(nmax * plen)), 1'b1)
      `CHECK(orderFault, 1'b0)
      $display("row %0d done, span %0d cycles", i, lastSpan);
    end
    // gating: switch off, then external enable grounded
    for (int g = 0; g < 2; g++) begin
      periodSel = 4'h0;
      manualOn = 1'(g);
      extEnable = 1'(1 - g);
      while (busy !== 1'b0) @(negedge clk);
      repeat (4) @(negedge clk);
      `CHECK(activeLamp, 1'b0)
      starts = 0;
      ticks = 0;
      repeat (3000) begin
        @(negedge clk);
        if (startPulse === 1'b1) starts++;
        if (periodTick === 1'b1) ticks++;
      end
      `CHECK(starts, 0)
      `CHECK(ticks, 3000 / int'(random_interval_pulse_pair_gen_pkg::BASE_CYC))
      manualOn = 1'b1;
      extEnable = 1'b1;
      repeat (4) @(negedge clk);
      `CHECK(activeLamp, 1'b1)
      $display("gating case %0d done", g);
    end
    // reset in mid-run clears every output, tick included
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    `CHECK({startPulse, stopPulse, busy, periodTick, activeLamp}, 5'h00)
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    `CHECK(activeLamp, 1'b1)
    $display("reset case done");
    final_report();
  end
endmodule // random_interval_pulse_pair_gen_tb
`default_nettype wire

// *** sim/tac_model.sv ***
// converter model on the start and stop inputs: measures each interval
// assumes start and stop are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module tac_model (
  // clock
  input wire logic clk,
  // converter inputs
  input wire logic startPulse,
  input wire logic stopPulse,
  // measurement results
  output logic [31:0] lastSpan,
  output logic [15:0] pairCount,
  output logic        orderFault
);
  logic [31:0] runCnt_q = 32'h0; // cycles since start
  logic        armed_q  = 1'b0;  // ramp running
  initial begin
    lastSpan   = 32'h0;
    pairCount  = 16'h0;
    orderFault = 1'b0;
  end
  // ramp starts on start, converts on stop; a second start or a lone stop is a fault
  always @(posedge clk) begin
    if (startPulse) begin
      orderFault <= orderFault | armed_q;
      armed_q    <= 1'b1;
      runCnt_q   <= 32'h1;
    end else if (stopPulse) begin
      orderFault <= orderFault | !armed_q;
      armed_q    <= 1'b0;
      lastSpan   <= runCnt_q;
      pairCount  <= pairCount + 16'h1;
    end else if (armed_q) begin
      runCnt_q <= runCnt_q + 32'h1;
    end
  end
endmodule // tac_model
`default_nettype wire
